// ==== rtl/deac_top.sv ====
// data nonvolatile array access control through special registers
// Behaviour
// - array of 64 bytes, 0h to 3Fh
// - byte buffer holds 8-bit read/write data
// - array reached by the core only via special registers; programmer has its own port
// - reads and writes in normal operation
// - write erases and programs the location in one commit
// - write time set by internal timer
// - core access allowed under code protection
// - programmer denied access under code protection
// - 8-bit pointer, lowest 64 implemented
// - control register at 88h, five bits
// - done flag bit 4, set on completion
// - abort flag bit 3 on interrupted write
// - write-start bit 1, set-only, hardware clears
// - read-start bit 0, one cycle, self-clears
// - write needs 55h, AAh, then start
// - start refused unless permit already set
// - read data lands next cycle, held
// - unlock key port reads zero, stores nothing
`timescale 1ns/1ps
module deac_top #(
    parameter int WRITE_CYCLES_P = deac_pkg::WRITE_CYCLES
) (
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire logic clk_en_i,
    input wire logic ext_reset_i,
    input wire logic wdt_reset_i,
    input wire logic code_protect_i,
    input wire logic [deac_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [deac_pkg::DATA_W-1:0] reg_wdata_i,
    input wire logic reg_we_i,
    input wire logic reg_re_i,
    output logic [deac_pkg::DATA_W-1:0] reg_rdata_o,
    input wire logic prog_req_i,
    input wire logic prog_we_i,
    input wire logic [deac_pkg::IDX_W-1:0] prog_idx_i,
    input wire logic [deac_pkg::DATA_W-1:0] prog_wdata_i,
    output logic [deac_pkg::DATA_W-1:0] prog_rdata_o,
    output logic prog_denied_o,
    output logic write_busy_o
);
    import deac_pkg::*;

    deac_mem_if mif ();

    deac_array #(
        .DEPTH_P(DEPTH)
    ) u_array (
        .core_clk_i(core_clk_i),
        .clk_en_i(clk_en_i),
        .mem(mif.mem)
    );

    logic [DATA_W-1:0] nv_byte_buffer_q;
    logic [ADDR_W-1:0] nv_location_pointer_q;
    logic write_done_flag_q;
    logic write_abort_flag_q;
    logic write_permit_q;
    logic wr_start_q;
    logic rd_start_q;
    logic [WCNT_W-1:0] wcnt_q;
    logic [WCNT_W-1:0] wcnt_d;
    deac_key_t key_q;
    deac_key_t key_d;

    localparam logic [WCNT_W-1:0] WLAST = WCNT_W'(WRITE_CYCLES_P - 1);
    localparam logic [WCNT_W-1:0] WCNT_ZERO = '0;

    // one comparator shape for every special register match
    function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] target);
        return addr == target;
    endfunction : reg_hit

    wire sel_data = reg_hit(reg_addr_i, DATA_ADDR);
    wire sel_ptr = reg_hit(reg_addr_i, PTR_ADDR);
    wire sel_ctrl = reg_hit(reg_addr_i, CTRL_ADDR);
    wire sel_key = reg_hit(reg_addr_i, KEY_ADDR);
    wire wr_data = reg_we_i && sel_data;
    wire wr_ptr = reg_we_i && sel_ptr;
    wire wr_ctrl = reg_we_i && sel_ctrl;
    wire wr_key = reg_we_i && sel_key;

    // upper two pointer bits take part in decode
    wire ptr_in_range = nv_location_pointer_q[ADDR_W-1:IDX_W] == UPPER_ZERO;
    wire abort_evt = ext_reset_i || wdt_reset_i;

    // start accepted only after the key pair and with permit already set
    wire start_req = wr_ctrl && reg_wdata_i[WR_BIT] && !wr_start_q;
    wire start_ok = start_req && key_q == DEAC_KEY_ARMED && write_permit_q;
    wire write_finish = wr_start_q && wcnt_q == WLAST;
    wire read_go = wr_ctrl && reg_wdata_i[RD_BIT] && !rd_start_q;

    // programmer shares the array port only while no write is in flight
    wire prog_ok = prog_req_i && !code_protect_i && !wr_start_q;
    assign prog_denied_o = prog_req_i && code_protect_i;

    // the whole byte is replaced in one commit: erase and program together
    assign mif.we = (write_finish && ptr_in_range) || (prog_ok && prog_we_i);
    assign mif.idx = prog_ok ? prog_idx_i : nv_location_pointer_q[IDX_W-1:0];
    assign mif.wdata = prog_ok ? prog_wdata_i : nv_byte_buffer_q;
    assign prog_rdata_o = prog_ok ? mif.rdata : ZERO_BYTE;

    wire [DATA_W-1:0] rd_byte = ptr_in_range ? mif.rdata : ZERO_BYTE;

    wire [DATA_W-1:0] ctrl_view = {3'h0, write_done_flag_q, write_abort_flag_q,
                                   write_permit_q, wr_start_q, rd_start_q};

    // unlock key port reads zero; unmapped addresses read zero too
    assign reg_rdata_o = !reg_re_i ? ZERO_BYTE :
                         sel_data ? nv_byte_buffer_q :
                         sel_ptr ? nv_location_pointer_q :
                         sel_ctrl ? ctrl_view : ZERO_BYTE;
    assign write_busy_o = wr_start_q;

    // any other bus write breaks the key sequence; a fresh 55h always restarts it
    always_comb begin
        key_d = key_q;
        case (key_q)
            DEAC_KEY_IDLE: begin
                if (wr_key && reg_wdata_i == KEY_FIRST) begin
                    key_d = DEAC_KEY_GOT1;
                end
            end
            DEAC_KEY_GOT1: begin
                if (wr_key && reg_wdata_i == KEY_SECOND) begin
                    key_d = DEAC_KEY_ARMED;
                end else if (wr_key && reg_wdata_i == KEY_FIRST) begin
                    key_d = DEAC_KEY_GOT1;
                end else if (reg_we_i) begin
                    key_d = DEAC_KEY_IDLE;
                end
            end
            DEAC_KEY_ARMED: begin
                if (wr_key && reg_wdata_i == KEY_FIRST) begin
                    key_d = DEAC_KEY_GOT1;
                end else if (reg_we_i) begin
                    key_d = DEAC_KEY_IDLE;
                end
            end
            default: begin
                key_d = DEAC_KEY_IDLE;
            end
        endcase
    end

    // counter rests at zero between writes so each write times from a clean start
    always_comb begin
        wcnt_d = WCNT_ZERO;
        if (wr_start_q && !write_finish) begin
            wcnt_d = wcnt_q + WCNT_W'(1);
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            key_q <= DEAC_KEY_IDLE;
            wcnt_q <= WCNT_ZERO;
        end else if (clk_en_i) begin
            // an abort also drops a half-entered key sequence
            key_q <= abort_evt ? DEAC_KEY_IDLE : key_d;
            wcnt_q <= abort_evt ? WCNT_ZERO : wcnt_d;
        end
    end

    // control bits; abort inputs clear permit and both start bits, set the abort flag if a write was running, and leave the done flag
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            write_permit_q <= 1'b0;
            wr_start_q <= 1'b0;
            rd_start_q <= 1'b0;
            write_done_flag_q <= 1'b0;
            write_abort_flag_q <= 1'b0;
        end else if (clk_en_i) begin
            if (abort_evt) begin
                write_permit_q <= 1'b0;
                wr_start_q <= 1'b0;
                rd_start_q <= 1'b0;
                write_abort_flag_q <= wr_start_q || write_abort_flag_q;
            end else begin
                if (wr_ctrl) begin
                    write_permit_q <= reg_wdata_i[PERMIT_BIT];
                    write_abort_flag_q <= reg_wdata_i[ABORT_BIT];
                end
                // completion beats a same-cycle software clear
                if (write_finish) begin
                    write_done_flag_q <= 1'b1;
                end else if (wr_ctrl) begin
                    write_done_flag_q <= reg_wdata_i[DONE_BIT];
                end
                if (start_ok) begin
                    wr_start_q <= 1'b1;
                end else if (write_finish) begin
                    wr_start_q <= 1'b0;
                end
                rd_start_q <= read_go;
            end
        end
    end

    // pointer and buffer keep their values across aborts so software can retry
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            nv_byte_buffer_q <= ZERO_BYTE;
            nv_location_pointer_q <= ZERO_BYTE;
        end else if (clk_en_i) begin
            if (wr_ptr) begin
                nv_location_pointer_q <= reg_wdata_i;
            end
            if (read_go) begin
                nv_byte_buffer_q <= rd_byte;
            end else if (wr_data) begin
                nv_byte_buffer_q <= reg_wdata_i;
            end
        end
    end
endmodule : deac_top

// ==== shared/deac_pkg.sv ====
// package: register map, field positions and timing for the data nonvolatile access block
package deac_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int DEPTH = 64;
    localparam int IDX_W = 6;
    // special register addresses
    localparam logic [7:0] DATA_ADDR = 8'h08;
    localparam logic [7:0] PTR_ADDR = 8'h09;
    localparam logic [7:0] CTRL_ADDR = 8'h88;
    localparam logic [7:0] KEY_ADDR = 8'h89;
    // control register fields
    localparam int RD_BIT = 0;
    localparam int WR_BIT = 1;
    localparam int PERMIT_BIT = 2;
    localparam int ABORT_BIT = 3;
    localparam int DONE_BIT = 4;
    // unlock key values
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'haa;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [1:0] UPPER_ZERO = 2'h0;
    // write time
    localparam int WRITE_TIME_US = 4000;
    localparam int CLK_MHZ = 250;
    localparam int WRITE_CYCLES = WRITE_TIME_US * CLK_MHZ;
    localparam int WCNT_W = 20;
    typedef enum logic [1:0] {
        DEAC_KEY_IDLE = 2'b00,
        DEAC_KEY_GOT1 = 2'b01,
        DEAC_KEY_ARMED = 2'b10
    } deac_key_t;
endpackage : deac_pkg

// ==== shared/deac_mem_if.sv ====
// interface: array port between controller and storage
`timescale 1ns/1ps
interface deac_mem_if;
    import deac_pkg::*;
    logic [IDX_W-1:0] idx;
    logic [DATA_W-1:0] wdata;
    logic we;
    logic [DATA_W-1:0] rdata;
    modport ctrl (output idx, output wdata, output we, input rdata);
    modport mem (input idx, input wdata, input we, output rdata);
endinterface : deac_mem_if

// ==== rtl/deac_array.sv ====
// storage array of byte locations held in flip-flops
`timescale 1ns/1ps
module deac_array #(
    parameter int DEPTH_P = 64
) (
    input wire logic core_clk_i,
    input wire logic clk_en_i,
    deac_mem_if.mem mem
);
    import deac_pkg::*;
    logic [DATA_W-1:0] cell_q [DEPTH_P];
    assign mem.rdata = cell_q[mem.idx];
    // no reset: array content is nonvolatile, survives resets
    always_ff @(posedge core_clk_i) begin
        if (clk_en_i && mem.we) begin
            cell_q[mem.idx] <= mem.wdata;
        end
    end
endmodule : deac_array

// ==== bench/deac_assertions.sv ====
// checker: port-level properties of the nonvolatile access block
`timescale 1ns/1ps
module deac_assertions #(
    parameter int WRITE_CYCLES_P = deac_pkg::WRITE_CYCLES
) (
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire logic ext_reset_i,
    input wire logic wdt_reset_i,
    input wire logic code_protect_i,
    input wire logic reg_we_i,
    input wire logic reg_re_i,
    input wire logic prog_req_i,
    input wire logic prog_denied_o,
    input wire logic write_busy_o,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic [7:0] prog_rdata_o
);
    import deac_pkg::*;
    logic [19:0] cnt_q;
    logic aa_q;
    wire ctl_rd = reg_re_i && reg_addr_i == CTRL_ADDR;
    wire ctl_wr = reg_we_i && reg_addr_i == CTRL_ADDR;
    wire start_req = ctl_wr && reg_wdata_i[WR_BIT];
    wire any_rst = ext_reset_i || wdt_reset_i;
    // only the last bus write is tracked, a looser test than the full key order
    always_ff @(posedge core_clk_i) begin
        cnt_q <= (reset_n_i && write_busy_o) ? cnt_q + 20'h1 : 20'h0;
        aa_q <= reset_n_i && (reg_we_i ? reg_addr_i == KEY_ADDR && reg_wdata_i == KEY_SECOND : aa_q);
    end
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);
    property p_deny; prog_req_i && code_protect_i |-> prog_denied_o && prog_rdata_o == ZERO_BYTE; endproperty
    a_deny: assert property (p_deny) else $error("programmer not refused");
    property p_key; reg_re_i && reg_addr_i == KEY_ADDR |-> reg_rdata_o == ZERO_BYTE; endproperty
    a_key: assert property (p_key) else $error("key port not zero");
    property p_top; ctl_rd |-> reg_rdata_o[7:5] == 3'h0; endproperty
    a_top: assert property (p_top) else $error("control upper bits set");
    property p_wrbit; ctl_rd |-> reg_rdata_o[WR_BIT] == write_busy_o; endproperty
    a_wrbit: assert property (p_wrbit) else $error("start bit differs from busy");
    property p_start; $rose(write_busy_o) |-> $past(start_req); endproperty
    a_start: assert property (p_start) else $error("write began unasked");
    property p_armed; ctl_wr && !aa_q && !write_busy_o |=> !write_busy_o; endproperty
    a_armed: assert property (p_armed) else $error("write began unkeyed");
    property p_abort; write_busy_o && any_rst |=> !write_busy_o; endproperty
    a_abort: assert property (p_abort) else $error("write not cut short");
    property p_len; $fell(write_busy_o) && $past(reset_n_i) && !$past(any_rst) |-> cnt_q == WRITE_CYCLES_P; endproperty
    a_len: assert property (p_len) else $error("write length wrong");
endmodule : deac_assertions
bind deac_top deac_assertions #(.WRITE_CYCLES_P(WRITE_CYCLES_P)) i_deac_assertions (
    .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .ext_reset_i(ext_reset_i), .wdt_reset_i(wdt_reset_i),
    .code_protect_i(code_protect_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .prog_req_i(prog_req_i),
    .prog_denied_o(prog_denied_o), .write_busy_o(write_busy_o), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .prog_rdata_o(prog_rdata_o));

// ==== bench/deac_core_model.sv ====
// partner model: processor core reaching the block through its special registers
`timescale 1ns/1ps
module deac_core_model (
    input wire logic core_clk_i,
    input wire logic [7:0] rdata_i,
    output logic [7:0] addr_o, wdata_o,
    output logic we_o, re_o
);
    import deac_pkg::*;
    logic [7:0] q;
    initial {addr_o, wdata_o, we_o, re_o} = 18'h0;
    // one access per call; the bus idles a cycle between accesses
    task automatic xfer(input logic w, input logic [7:0] a, d, output logic [7:0] r);
        @(posedge core_clk_i);
        {addr_o, wdata_o, we_o, re_o} <= {a, d, w, !w};
        // read data taken mid-cycle, where it has settled and equals what the taking edge sees
        @(negedge core_clk_i);
        r = rdata_i;
        @(posedge core_clk_i);
        {we_o, re_o} <= 2'h0;
    endtask : xfer
    // permit goes up before the key pair so the start is not refused
    task automatic write_byte(input logic [7:0] idx, d);
        xfer(1'b1, PTR_ADDR, idx, q);
        xfer(1'b1, DATA_ADDR, d, q);
        xfer(1'b1, CTRL_ADDR, 8'h04, q);
        xfer(1'b1, KEY_ADDR, KEY_FIRST, q);
        xfer(1'b1, KEY_ADDR, KEY_SECOND, q);
        xfer(1'b1, CTRL_ADDR, 8'h06, q);
    endtask : write_byte
endmodule : deac_core_model

// ==== bench/data_eeprom_access_control_test.sv ====
// testbench: register-level scenarios for the nonvolatile access block
`timescale 1ns/1ps
module data_eeprom_access_control_test;
    import deac_pkg::*;
    localparam int WC = 8;
    logic core_clk_i, reset_n_i, ext_reset_i, wdt_reset_i, code_protect_i, reg_we_i, reg_re_i, prog_req_i;
    logic clk_en_i = 1'b1;
    logic prog_we_i = 1'b0;
    logic [5:0] prog_idx_i = 6'h3f;
    logic [7:0] prog_wdata_i = 8'h00;
    logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, prog_rdata_o, v;
    logic prog_denied_o, write_busy_o;
    int n_errors = 0;
    int n_compared = 0;
    deac_top #(.WRITE_CYCLES_P(WC)) i_deac_top (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
        .clk_en_i(clk_en_i), .ext_reset_i(ext_reset_i), .wdt_reset_i(wdt_reset_i), .code_protect_i(code_protect_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
        .reg_rdata_o(reg_rdata_o), .prog_req_i(prog_req_i), .prog_we_i(prog_we_i), .prog_idx_i(prog_idx_i),
        .prog_wdata_i(prog_wdata_i), .prog_rdata_o(prog_rdata_o), .prog_denied_o(prog_denied_o),
        .write_busy_o(write_busy_o));
    deac_core_model i_deac_core_model (.core_clk_i(core_clk_i), .rdata_i(reg_rdata_o), .addr_o(reg_addr_i),
        .wdata_o(reg_wdata_i), .we_o(reg_we_i), .re_o(reg_re_i));
    initial begin
        core_clk_i = 1'b0;
        forever #2 core_clk_i = ~core_clk_i;
    end
    initial begin
        #20000 n_errors++;
        complete_run();
    end
    task automatic chk(input string what, input logic [7:0] seen, want);
        n_compared++;
        if (seen !== want) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, want, seen);
        end
    endtask : chk
    task automatic rchk(input string what, input logic [7:0] a, want);
        i_deac_core_model.xfer(1'b0, a, 8'h00, v);
        chk(what, v, want);
    endtask : rchk
    task automatic wr(input logic [7:0] a, d);
        i_deac_core_model.xfer(1'b1, a, d, v);
    endtask : wr
    task automatic rdloc(input logic [7:0] idx, want);
        wr(PTR_ADDR, idx);
        wr(CTRL_ADDR, 8'h01);
        rchk("byte", DATA_ADDR, want);
    endtask : rdloc
    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : complete_run
    initial begin
        {reset_n_i, ext_reset_i, wdt_reset_i, code_protect_i, prog_req_i} = 5'h0;
        repeat (8) @(posedge core_clk_i);
        reset_n_i <= 1'b1;
        rchk("ctrl", CTRL_ADDR, 8'h00);
        rchk("key", KEY_ADDR, 8'h00);
        i_deac_core_model.write_byte(8'h3f, 8'ha5);
        rchk("busy", CTRL_ADDR, 8'h06);
        repeat (WC) @(posedge core_clk_i);
        rchk("done", CTRL_ADDR, 8'h14);
        rdloc(8'h3f, 8'ha5);
        $display("write test done");
        wr(CTRL_ADDR, 8'h04);
        wr(KEY_ADDR, KEY_SECOND);
        wr(KEY_ADDR, KEY_FIRST);
        wr(CTRL_ADDR, 8'h06);
        rchk("order", CTRL_ADDR, 8'h04);
        wr(CTRL_ADDR, 8'h00);
        wr(KEY_ADDR, KEY_FIRST);
        wr(KEY_ADDR, KEY_SECOND);
        wr(CTRL_ADDR, 8'h02);
        rchk("permit", CTRL_ADDR, 8'h00);
        rdloc(8'h40, 8'h00);
        i_deac_core_model.write_byte(8'h7f, 8'hff);
        repeat (WC + 2) @(posedge core_clk_i);
        rdloc(8'h3f, 8'ha5);
        $display("refusal test done");
        code_protect_i <= 1'b1;
        prog_req_i <= 1'b1;
        prog_we_i <= 1'b1;
        @(negedge core_clk_i);
        chk("deny", {7'h0, prog_denied_o}, 8'h01);
        chk("prog", prog_rdata_o, 8'h00);
        rdloc(8'h3f, 8'ha5);
        code_protect_i <= 1'b0;
        prog_we_i <= 1'b0;
        @(negedge core_clk_i);
        chk("prog", prog_rdata_o, 8'ha5);
        @(posedge core_clk_i);
        prog_req_i <= 1'b0;
        $display("protect test done");
        for (int i = 0; i < 2; i++) begin
            i_deac_core_model.write_byte(8'h01, 8'h33);
            {ext_reset_i, wdt_reset_i} <= (i == 0) ? 2'b10 : 2'b01;
            @(posedge core_clk_i);
            {ext_reset_i, wdt_reset_i} <= 2'b00;
            rchk("abort", CTRL_ADDR, 8'h08);
            rchk("kept", DATA_ADDR, 8'h33);
        end
        $display("abort test done");
        complete_run();
    end
endmodule : data_eeprom_access_control_test
